// ==== hdl/fanout_ctrl_defines.vh ====
`ifndef FANOUT_CTRL_DEFINES_VH
`define FANOUT_CTRL_DEFINES_VH
`define NUM_OUTPUTS 20
`define REG_OE_A 8'h00
`define REG_OE_B 8'h01
`define REG_OE_C 8'h02
`define REG_PIN_LEVELS 8'h03
`define REG_SCHEME 8'h04
`define REG_REVISION 8'h05
`define REG_PART_ID 8'h06
`define REG_READ_LEN 8'h07
`define REG_MASK_A 8'h08
`define REG_MASK_B 8'h09
`define REG_MASK_C 8'h0A
`define REG_SWING 8'h14
`define RST_OE_A 8'h78
`define RST_OE_B 8'hFF
`define RST_OE_C 8'hFF
`define RST_READ_LEN 5'h07
`define RST_MASK 8'h00
`define RST_SWING 8'h00
`define RST_SHIFT 20'hFFFFF
`define OE_A_WMASK 8'h7F
`define MASK_C_WMASK 8'h0F
`define SWING_WMASK 8'hFF
// Arbitrary identification values
`define REVISION_VALUE 8'h00
`define PART_ID_VALUE 8'h5A
`define CLK_PERIOD_PS 5000
`define T_STABLE_US 1800
`define T_RESTART_US 300
`define STABLE_CYCLES (`T_STABLE_US * 1000000 / `CLK_PERIOD_PS)
`define RESTART_CYCLES (`T_RESTART_US * 1000000 / `CLK_PERIOD_PS)
`define STRAP_LOW 2'h0
`define STRAP_MID 2'h1
`define STRAP_HIGH 2'h2
`endif

// ==== hdl/sync_bank.v ====
`timescale 1ns/1ps
// Two-stage synchroniser for a bank of asynchronous levels
module sync_bank #(
    parameter WIDTH = 1
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Levels
    input wire [WIDTH-1:0] async_i,
    output wire [WIDTH-1:0] sync_o
);
    reg [WIDTH-1:0] meta_ff;
    reg [WIDTH-1:0] sync_ff;

    // First stage feeds only the second
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            meta_ff <= {WIDTH{1'b0}};
            sync_ff <= {WIDTH{1'b0}};
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;
endmodule

// ==== hdl/fanout_ctrl.v ====
`timescale 1ns/1ps
`include "fanout_ctrl_defines.vh"
module fanout_ctrl #(
    parameter STABLE_CYCLES = `STABLE_CYCLES,
    parameter RESTART_CYCLES = `RESTART_CYCLES
) (
    // Clock and reset
    input wire clk_i,
    input wire reset_n_i,
    // Power good and reference
    input wire power_good_or_sleep_n_i,
    input wire reference_complement_in_i,
    // Scheme select and enable pins 5..12
    input wire sideband_scheme_pin_i,
    input wire [7:0] pair_enable_pin_n_i,
    // Address straps, three-level coded
    input wire [1:0] address_strap_low_i,
    input wire [1:0] address_strap_high_i,
    // Management register port
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [7:0] reg_addr_i,
    input wire [7:0] reg_wdata_i,
    output reg [7:0] reg_rdata_o,
    output reg reg_ack_o,
    // Output controls
    output reg [19:0] output_run_o,
    output reg [6:0] bus_address_o,
    output reg [2:0] swing_select_o,
    output reg [1:0] stop_level_o,
    output reg [4:0] block_read_len_o,
    output reg outputs_stable_o
);
    // Synchronised copies of pins
    wire [12:0] pins_s;
    wire pgood_s;
    wire ref_s;
    wire sb_sel_s;
    wire [7:0] oe_pin_s;
    wire [1:0] strap_lo_s;
    wire [1:0] strap_hi_s;

    // Every outside level except the register port passes two flops
    sync_bank #(
        .WIDTH(13)
    ) u_sync (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .async_i({address_strap_high_i, address_strap_low_i, sideband_scheme_pin_i,
            pair_enable_pin_n_i}),
        .sync_o(pins_s)
    );
    reg pgood_meta_ff;
    reg pgood_sync_ff;
    reg ref_meta_ff;
    reg ref_sync_ff;
    reg ref_prev_ff;

    // Power good and reference are asynchronous inputs; plain two-flop path
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            pgood_meta_ff <= 1'b0;
            pgood_sync_ff <= 1'b0;
            ref_meta_ff <= 1'b0;
            ref_sync_ff <= 1'b0;
            ref_prev_ff <= 1'b0;
        end else begin
            pgood_meta_ff <= power_good_or_sleep_n_i;
            pgood_sync_ff <= pgood_meta_ff;
            ref_meta_ff <= reference_complement_in_i;
            ref_sync_ff <= ref_meta_ff;
            ref_prev_ff <= ref_sync_ff;
        end
    end
    // Named taps of the synchronised levels
    assign pgood_s = pgood_sync_ff;
    assign ref_s = ref_sync_ff;
    assign oe_pin_s = pins_s[7:0];
    assign sb_sel_s = pins_s[8];
    assign strap_lo_s = pins_s[10:9];
    assign strap_hi_s = pins_s[12:11];

    // Reference complement edges as seen by the system clock
    wire ref_rise = ref_s & ~ref_prev_ff;
    wire ref_fall = ~ref_s & ref_prev_ff;

    // Three-level strap pair to 8-bit bus byte
    function [7:0] strap_addr;
        input [1:0] hi;
        input [1:0] lo;
        begin
            case ({hi, lo})
                {`STRAP_LOW, `STRAP_LOW}: strap_addr = 8'hD8;
                {`STRAP_LOW, `STRAP_MID}: strap_addr = 8'hDA;
                {`STRAP_LOW, `STRAP_HIGH}: strap_addr = 8'hDE;
                {`STRAP_MID, `STRAP_LOW}: strap_addr = 8'hC2;
                {`STRAP_MID, `STRAP_MID}: strap_addr = 8'hC4;
                {`STRAP_MID, `STRAP_HIGH}: strap_addr = 8'hC6;
                {`STRAP_HIGH, `STRAP_LOW}: strap_addr = 8'hCA;
                {`STRAP_HIGH, `STRAP_MID}: strap_addr = 8'hCC;
                {`STRAP_HIGH, `STRAP_HIGH}: strap_addr = 8'hCE;
                default: strap_addr = 8'hD8;
            endcase
        end
    endfunction

    // Power sequencing states
    localparam ST_WAIT_FIRST = 2'h0;
    localparam ST_RUN = 2'h1;
    localparam ST_STOPPED = 2'h2;
    localparam ST_RESTART = 2'h3;

    // Sequencer registers
    reg [1:0] state_ff;
    reg [1:0] nxt_state;
    reg configured_ff;
    reg [1:0] low_seen_ff;
    reg stop_pending_ff;
    reg [19:0] timer_ff;
    reg [19:0] nxt_timer;

    // Sample low on two consecutive reference-complement rises
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            low_seen_ff <= 2'h0;
            stop_pending_ff <= 1'b0;
        end else begin
            if (pgood_s) begin
                low_seen_ff <= 2'h0;
            end else if (ref_rise && low_seen_ff != 2'h2) begin
                low_seen_ff <= low_seen_ff + 2'h1;
            end
            if (pgood_s) begin
                stop_pending_ff <= 1'b0;
            end else if (low_seen_ff == 2'h2) begin
                stop_pending_ff <= 1'b1;
            end
        end
    end
    // Stop lands on the reference fall after the second low sample
    wire stop_now = stop_pending_ff & ref_fall;

    // Power sequencing next state
    always @* begin
        nxt_state = state_ff;
        nxt_timer = timer_ff;
        case (state_ff)
            ST_WAIT_FIRST: begin
                if (pgood_s) begin
                    nxt_state = ST_RESTART;
                    nxt_timer = STABLE_CYCLES[19:0];
                end
            end
            ST_RUN: begin
                if (stop_now) begin
                    nxt_state = ST_STOPPED;
                end
            end
            ST_STOPPED: begin
                if (pgood_s) begin
                    nxt_state = ST_RESTART;
                    nxt_timer = RESTART_CYCLES[19:0];
                end
            end
            ST_RESTART: begin
                if (stop_now) begin
                    nxt_state = ST_STOPPED;
                end else if (timer_ff == 20'h00000 || ref_fall) begin
                    // Restart on timer expiry or on the first reference fall
                    nxt_state = ST_RUN;
                end else begin
                    nxt_timer = timer_ff - 20'h00001;
                end
            end
            default: nxt_state = ST_WAIT_FIRST;
        endcase
    end

    // Strap decode as an 8-bit bus byte; the address is its upper seven bits
    wire [7:0] strap_byte;
    assign strap_byte = strap_addr(strap_hi_s, strap_lo_s);

    // Sequencer state and one-time strap capture
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            state_ff <= ST_WAIT_FIRST;
            timer_ff <= 20'h00000;
            configured_ff <= 1'b0;
            bus_address_o <= 7'h6C;
        end else begin
            state_ff <= nxt_state;
            timer_ff <= nxt_timer;
            if (pgood_s && !configured_ff) begin
                configured_ff <= 1'b1;
                bus_address_o <= strap_byte[7:1];
            end
        end
    end

    // Side-band lines reuse pins 5, 6 and 10
    wire sb_data = oe_pin_s[0];
    wire sb_clk = oe_pin_s[1];
    wire sb_strobe = oe_pin_s[5];
    reg sb_clk_prev_ff;
    reg sb_strobe_prev_ff;
    reg sb_sel_prev_ff;
    reg [19:0] shift_ff;
    reg [19:0] sb_out_ff;

    // Edges count only once the select has settled, so a mode switch is no edge
    wire sb_live = sb_sel_s & sb_sel_prev_ff;

    // Shift on clock rise while strobe high, load on strobe fall
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            sb_clk_prev_ff <= 1'b0;
            sb_strobe_prev_ff <= 1'b0;
            sb_sel_prev_ff <= 1'b0;
            shift_ff <= `RST_SHIFT;
            sb_out_ff <= `RST_SHIFT;
        end else begin
            sb_clk_prev_ff <= sb_clk;
            sb_strobe_prev_ff <= sb_strobe;
            sb_sel_prev_ff <= sb_sel_s;
            // Works regardless of power good
            if (sb_live) begin
                if (sb_strobe && sb_clk && !sb_clk_prev_ff) begin
                    shift_ff <= {shift_ff[18:0], sb_data};
                end
                if (!sb_strobe && sb_strobe_prev_ff) begin
                    sb_out_ff <= shift_ff;
                end
            end
        end
    end

    // Management registers
    reg [7:0] oe_a_ff;
    reg [7:0] oe_b_ff;
    reg [7:0] oe_c_ff;
    reg [7:0] mask_a_ff;
    reg [7:0] mask_b_ff;
    reg [7:0] mask_c_ff;
    reg [4:0] read_len_ff;
    reg [7:0] swing_ff;
    wire bus_ok = pgood_s;

    // Register writes
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            oe_a_ff <= `RST_OE_A;
            oe_b_ff <= `RST_OE_B;
            oe_c_ff <= `RST_OE_C;
            mask_a_ff <= `RST_MASK;
            mask_b_ff <= `RST_MASK;
            mask_c_ff <= `RST_MASK;
            read_len_ff <= `RST_READ_LEN;
            swing_ff <= `RST_SWING;
        end else if (reg_wr_i && bus_ok) begin
            case (reg_addr_i)
                `REG_OE_A: oe_a_ff <= reg_wdata_i & `OE_A_WMASK;
                `REG_OE_B: oe_b_ff <= reg_wdata_i;
                `REG_OE_C: oe_c_ff <= reg_wdata_i;
                `REG_READ_LEN: read_len_ff <= reg_wdata_i[4:0];
                `REG_MASK_A: mask_a_ff <= reg_wdata_i;
                `REG_MASK_B: mask_b_ff <= reg_wdata_i;
                `REG_MASK_C: mask_c_ff <= reg_wdata_i & `MASK_C_WMASK;
                `REG_SWING: swing_ff <= reg_wdata_i & `SWING_WMASK;
                default: swing_ff <= swing_ff;
            endcase
        end
    end

    // Register reads and acknowledge
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            reg_rdata_o <= 8'h00;
            reg_ack_o <= 1'b0;
        end else begin
            reg_ack_o <= (reg_wr_i | reg_rd_i) & bus_ok;
            if (reg_rd_i && bus_ok) begin
                case (reg_addr_i)
                    `REG_OE_A: reg_rdata_o <= oe_a_ff;
                    `REG_OE_B: reg_rdata_o <= oe_b_ff;
                    `REG_OE_C: reg_rdata_o <= oe_c_ff;
                    `REG_PIN_LEVELS: reg_rdata_o <= oe_pin_s;
                    `REG_SCHEME: reg_rdata_o <= {7'h00, sb_sel_s};
                    `REG_REVISION: reg_rdata_o <= `REVISION_VALUE;
                    `REG_PART_ID: reg_rdata_o <= `PART_ID_VALUE;
                    `REG_READ_LEN: reg_rdata_o <= {3'h0, read_len_ff};
                    `REG_MASK_A: reg_rdata_o <= mask_a_ff;
                    `REG_MASK_B: reg_rdata_o <= mask_b_ff;
                    `REG_MASK_C: reg_rdata_o <= mask_c_ff;
                    `REG_SWING: reg_rdata_o <= swing_ff;
                    default: reg_rdata_o <= 8'h00;
                endcase
            end else begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // Per-output enable from the selected scheme
    wire [19:0] en_bits = {oe_a_ff[6:3], oe_c_ff, oe_b_ff};
    wire [19:0] mask_bits = {mask_c_ff[3:0], mask_b_ff, mask_a_ff};
    reg [19:0] nxt_want;
    integer i;

    // Wanted run state of each output under the selected scheme
    always @* begin
        nxt_want = 20'h00000;
        for (i = 0; i < 20; i = i + 1) begin
            if (sb_sel_s) begin
                // Mask forces output on in side-band mode
                nxt_want[i] = sb_out_ff[i] | mask_bits[i];
            end else if (i >= 5 && i <= 12) begin
                nxt_want[i] = en_bits[i] & ~oe_pin_s[i-5];
            end else begin
                nxt_want[i] = en_bits[i];
            end
        end
    end

    // Glitch-free gate: run enables load only at reference fall; the other controls follow every cycle
    always @(posedge clk_i) begin
        if (!reset_n_i) begin
            output_run_o <= 20'h00000;
            outputs_stable_o <= 1'b0;
            swing_select_o <= 3'h0;
            stop_level_o <= 2'h0;
            block_read_len_o <= `RST_READ_LEN;
        end else begin
            if (state_ff != ST_RUN) begin
                output_run_o <= 20'h00000;
            end else if (ref_fall) begin
                output_run_o <= nxt_want;
            end
            outputs_stable_o <= (state_ff == ST_RUN);
            swing_select_o <= swing_ff[7:5];
            stop_level_o <= swing_ff[1:0];
            block_read_len_o <= read_len_ff;
        end
    end
endmodule

// ==== tb/fanout_ctrl_props.sv ====
`timescale 1ns/1ps
// Port checks of the fan-out control block
module fanout_ctrl_props #(
    parameter STABLE_CYCLES = 50,
    parameter RESTART_CYCLES = 20
) (
    // Clock, reset and power good
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic power_good_or_sleep_n_i,
    // Register port
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic reg_ack_o,
    // Output controls
    input wire logic [19:0] output_run_o,
    input wire logic [6:0] bus_address_o,
    input wire logic [2:0] swing_select_o,
    input wire logic [1:0] stop_level_o,
    input wire logic [4:0] block_read_len_o,
    input wire logic outputs_stable_o
);
    logic [31:0] wait_cnt;
    logic [5:0] low_cnt;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);
    // Cycles spent waiting for run state and spent powered down
    always @(posedge clk_i) begin
        if (!reset_n_i || !power_good_or_sleep_n_i || outputs_stable_o)
            wait_cnt <= 0;
        else
            wait_cnt <= wait_cnt + 1;
        if (!reset_n_i || power_good_or_sleep_n_i)
            low_cnt <= 0;
        else if (low_cnt != 6'h3F)
            low_cnt <= low_cnt + 1;
    end
    // Named steps of power good and register traffic
    sequence pg_low4;
        !power_good_or_sleep_n_i [*4];
    endsequence
    sequence len_read;
        (reg_rd_i && reg_addr_i == 8'h07) ##1 reg_ack_o;
    endsequence
    property p_wr_len;
        logic [4:0] d;
        (reg_wr_i && reg_addr_i == 8'h07, d = reg_wdata_i[4:0]) ##1 reg_ack_o
            |-> ##[0:1] block_read_len_o == d;
    endproperty
    property p_wr_swing;
        logic [7:0] d;
        (reg_wr_i && reg_addr_i == 8'h14, d = reg_wdata_i) ##1 reg_ack_o
            |-> ##[0:1] {swing_select_o, stop_level_o} == {d[7:5], d[1:0]};
    endproperty
    a_reset_values: assert property ($rose(reset_n_i) |->
        bus_address_o == 7'h6C && block_read_len_o == 5'h07)
        else $error("wrong values after reset");
    a_refused_low: assert property (pg_low4 |=> !reg_ack_o)
        else $error("answer while power good low");
    a_ack_cause: assert property (reg_ack_o |-> $past(reg_wr_i) || $past(reg_rd_i))
        else $error("answer without request");
    a_stop_in_sleep: assert property (low_cnt == 6'h3F |-> output_run_o == 20'h0)
        else $error("outputs run in power down");
    a_start_bound: assert property (wait_cnt <= STABLE_CYCLES + 30)
        else $error("run state late");
    a_addr_held: assert property (
        outputs_stable_o && $past(outputs_stable_o) |-> $stable(bus_address_o))
        else $error("bus address changed");
    a_len_write: assert property (p_wr_len)
        else $error("read length not updated");
    a_len_read: assert property (len_read |-> reg_rdata_o == {3'h0, block_read_len_o})
        else $error("read length readback wrong");
    a_swing_write: assert property (p_wr_swing)
        else $error("swing or stop level not updated");
endmodule

bind fanout_ctrl fanout_ctrl_props #(
    .STABLE_CYCLES(STABLE_CYCLES),
    .RESTART_CYCLES(RESTART_CYCLES)
) fanout_ctrl_props_i (.*);

// ==== tb/sideband_host.sv ====
`timescale 1ns/1ps
// Side-band controller: frames at a 125 ns link period
module sideband_host (
    // Clock
    input wire logic clk_i,
    // Side-band lines
    output logic data_o,
    output logic sclk_o,
    output logic strobe_o
);
    // Idle: clock parked low, lines at their pull-down level
    initial begin
        data_o = 1'b0;
        sclk_o = 1'b0;
        strobe_o = 1'b0;
    end
    // Wait n system cycles
    task automatic half(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // 20-bit frame, first bit ends in output 19; sel low leaves strobe low
    task automatic send(input logic [19:0] w, input logic sel);
        strobe_o = sel;
        for (int i = 19; i >= 0; i--) begin
            data_o = w[i];
            half(12);
            sclk_o = 1'b1;
            half(13);
            sclk_o = 1'b0;
        end
        data_o = 1'b0;
        half(12);
        strobe_o = 1'b0;
        half(12);
    endtask
    // Strobe pulse with no clocks: loads the shift register as it stands
    task automatic load_only;
        strobe_o = 1'b1;
        half(12);
        strobe_o = 1'b0;
        half(12);
    endtask
endmodule

// ==== tb/fanout_ctrl_bench.sv ====
`timescale 1ns/1ps
`include "fanout_ctrl_defines.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin mismatches++; \
    $display("FAIL %s exp %0h got %0h", n, e, g); end end
module fanout_ctrl_bench;
    logic clk_i = 0;
    logic reset_n_i = 0;
    logic pg = 0;
    logic ref_c = 0;
    logic sb = 0;
    logic [7:0] pins = 0;
    logic [1:0] s_lo = 0;
    logic [1:0] s_hi = 0;
    logic wr = 0;
    logic rd = 0;
    logic [7:0] addr = 0;
    logic [7:0] wdata = 0;
    logic [7:0] rdata, rv, w8, oa, ob, oc;
    logic ack, ak, sd, sc, ss, stable;
    logic [19:0] run, m, w;
    logic [6:0] ba;
    logic [2:0] sw;
    logic [1:0] sl;
    logic [4:0] len;
    int mismatches = 0;
    int cmp_count = 0;
    logic [7:0] at [9] = '{8'hD8, 8'hDA, 8'hDE, 8'hC2, 8'hC4, 8'hC6, 8'hCA, 8'hCC, 8'hCE};
    logic [7:0] ra [13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 8'h0A, 8'h14, 8'h30};
    logic [7:0] rx [13] = '{`RST_OE_A, 8'hFF, 8'hFF, 0, 0, `REVISION_VALUE,
        `PART_ID_VALUE, 8'h07, 0, 0, 0, 0, 0};
    wire [7:0] pin_w = sb ? {pins[7:6], ss, pins[4:2], sc, sd} : pins;

    // Clocks: system and free-running reference
    initial forever #2.5 clk_i = ~clk_i;
    initial forever #23 ref_c = ~ref_c;

    fanout_ctrl #(.STABLE_CYCLES(50), .RESTART_CYCLES(20)) fanout_ctrl_i (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .power_good_or_sleep_n_i(pg),
        .reference_complement_in_i(ref_c),
        .sideband_scheme_pin_i(sb),
        .pair_enable_pin_n_i(pin_w),
        .address_strap_low_i(s_lo),
        .address_strap_high_i(s_hi),
        .reg_wr_i(wr),
        .reg_rd_i(rd),
        .reg_addr_i(addr),
        .reg_wdata_i(wdata),
        .reg_rdata_o(rdata),
        .reg_ack_o(ack),
        .output_run_o(run),
        .bus_address_o(ba),
        .swing_select_o(sw),
        .stop_level_o(sl),
        .block_read_len_o(len),
        .outputs_stable_o(stable)
    );
    sideband_host sideband_host_i (.clk_i(clk_i), .data_o(sd), .sclk_o(sc), .strobe_o(ss));

    // Expected run enables of the pin scheme
    function automatic logic [19:0] trad(input logic [7:0] a, b, c, p);
        logic [19:0] r;
        r = {a[6:3], c, b};
        for (int k = 0; k < 8; k++)
            if (p[k])
                r[5 + k] = 1'b0;
        return r;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    // One register access; answer captured one cycle later
    task automatic op(input logic wn, input logic [7:0] a, input logic [7:0] d);
        tick(1);
        wr = wn;
        rd = !wn;
        addr = a;
        wdata = d;
        tick(1);
        wr = 0;
        rd = 0;
        ak = ack;
        rv = rdata;
    endtask
    task automatic wait_run(input logic [19:0] e);
        for (int n = 0; n < 300 && run !== e; n++)
            tick(1);
        `CHK("output_run_o", e, run)
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #400000;
        mismatches++;
        complete_run;
    end

    // Main sequence
    initial begin
        void'($urandom(32'h975E));
        for (int i = 0; i < 9; i++) begin
            pg = 0;
            s_hi = 2'(i / 3);
            s_lo = 2'(i % 3);
            reset_n_i = 0;
            tick(8);
            reset_n_i = 1;
            `CHK("bus_address_o", 7'h6C, ba)
            op(1, 8'h07, 8'h03);
            `CHK("ack and length", 6'h07, {ak, len})
            pg = 1;
            wait_run(20'hFFFFF);
            `CHK("outputs_stable_o", 1'b1, stable)
            s_hi = 2'h2 - s_hi;
            s_lo = 2'h2 - s_lo;
            tick(20);
            `CHK("bus_address_o", at[i][7:1], ba)
        end
        foreach (ra[k]) begin
            op(0, ra[k], 0);
            `CHK("read data", {1'b1, rx[k]}, {ak, rv})
        end
        for (int i = 0; i < 6; i++) begin
            {oa, ob, oc, pins} = $urandom;
            if (i == 0)
                pins = 8'hFF;
            op(1, 8'h00, oa);
            op(1, 8'h01, ob);
            op(1, 8'h02, oc);
            op(0, 8'h00, 0);
            `CHK("enable byte a", oa & 8'h7F, rv)
            op(0, 8'h03, 0);
            `CHK("pin levels", pins, rv)
            wait_run(trad(oa, ob, oc, pins));
        end
        m = 20'($urandom);
        op(1, 8'h08, m[7:0]);
        op(1, 8'h09, m[15:8]);
        op(1, 8'h0A, {4'h0, m[19:16]});
        tick(10);
        wait_run(trad(oa, ob, oc, pins));
        for (int i = 0; i < 8; i++) begin
            w8 = {3'(i), 3'($urandom), 2'(i)};
            op(1, 8'h14, w8);
            op(1, 8'h07, w8);
            op(0, 8'h14, 0);
            `CHK("swing readback", w8, rv)
            op(0, 8'h07, 0);
            `CHK("length readback", {3'h0, w8[4:0]}, rv)
            `CHK("swing and level", {w8[7:5], w8[1:0]}, {sw, sl})
        end
        sb = 1;
        tick(10);
        op(0, 8'h04, 0);
        `CHK("scheme readback", 8'h01, rv)
        wait_run(20'hFFFFF);
        for (int i = 0; i < 4; i++) begin
            w = (i == 0) ? 20'h00001 : 20'($urandom);
            pins = 8'($urandom);
            sideband_host_i.send(w, 1'b1);
            wait_run(w | m);
        end
        sideband_host_i.send(~w, 1'b0);
        tick(20);
        `CHK("ignored frame", w | m, run)
        // A bare load shows whether the frame under a low strobe left a trace
        sideband_host_i.load_only;
        tick(20);
        `CHK("load after ignored frame", w | m, run)
        // Reference keeps running through the power-down request
        pg = 0;
        wait_run(20'h0);
        `CHK("outputs_stable_o", 1'b0, stable)
        op(1, 8'h08, 8'hFF);
        `CHK("refused ack", 1'b0, ak)
        w = 20'($urandom);
        sideband_host_i.send(w, 1'b1);
        pg = 1;
        wait_run(w | m);
        sb = 0;
        wait_run(trad(oa, ob, oc, pins));
        complete_run;
    end
endmodule
